//--- cursor_depth_pll_config_regs.sv
// Cursor, pixel depth, product code and PLL divider registers behind AXI4-Lite
// How it works
// - Cursor-set command loads 15-bit cursor from low byte and seven high bits.
// - In indirect mode direct display memory access is refused.
// - In indirect mode, memory read/write commands use cursor then auto-increment it; otherwise they do nothing.
// - Scroll leaves cursor unchanged.
// - Without new set, accesses continue from last advanced address.
// - Readback registers show cursor, low and high parts, reset to zero.
// - Depth field 00/01/10 gives 1/2/4 bpp, 11 reserved.
// - Product ID register read returns fixed 8-bit product code.
// - PLL configuration command passes PLL registers to the PLL.
// - Upper nibble sets output divider, code plus one, 1 to 16.
// - Lower nibble sets input divider 1 to 13; codes above Ch reserved.
// - Second register low nibble sets feedback multiplier 1 to 16.
`default_nettype none
module cursor_depth_pll_config_regs
#(
  parameter logic [7:0] PRODUCT_CODE = cursor_regs_pkg::PRODUCT_CODE_DEFAULT // Arbitrary value
) (
  input  wire logic        i_clock,          // 100 MHz clock
  input  wire logic        i_srst,           // Sync reset, high
  input  wire logic [7:0]  i_awaddr,         // Write address
  input  wire logic        i_awvalid,        // Write address valid
  output logic             o_awready,        // Write address ready
  input  wire logic [31:0] i_wdata,          // Write data
  input  wire logic [3:0]  i_wstrb,          // Write strobes
  input  wire logic        i_wvalid,         // Write data valid
  output logic             o_wready,         // Write data ready
  output logic [1:0]       o_bresp,          // Write response
  output logic             o_bvalid,         // Write response valid
  input  wire logic        i_bready,         // Write response ready
  input  wire logic [7:0]  i_araddr,         // Read address
  input  wire logic        i_arvalid,        // Read address valid
  output logic             o_arready,        // Read address ready
  output logic [31:0]      o_rdata,          // Read data
  output logic [1:0]       o_rresp,          // Read response
  output logic             o_rvalid,         // Read data valid
  input  wire logic        i_rready,         // Read data ready
  output logic [14:0]      o_mem_addr,       // Display memory address
  output logic             o_mem_read,       // Memory read strobe
  output logic             o_mem_write,      // Memory write strobe
  output logic [1:0]       o_bits_per_pixel, // Applied depth code
  output logic [3:0]       o_input_ratio,    // Applied PLL input divider code
  output logic [3:0]       o_output_ratio,   // Applied output divider code
  output logic [3:0]       o_feedback_mult,  // Applied feedback multiplier code
  output logic             o_pll_load,       // PLL parameter load pulse
  output logic             o_direct_refused  // Direct access refused flag
);
  import cursor_regs_pkg::*;
  // Byte enable of the low lane
  function automatic logic low_lane(input logic [3:0] strb);
    low_lane = strb[0];
  endfunction

  logic        aw_held_reg, w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic [7:0]  set_low_reg;
  logic [6:0]  set_high_reg;
  logic [14:0] cursor_reg, cursor_next;
  logic [14:0] readback_reg;
  logic [1:0]  depth_reg;
  logic [7:0]  pll_div_reg;
  logic [7:0]  pll_mult_reg;
  logic        indirect_reg;
  logic        wr_go;
  logic        wr_known;
  logic [2:0]  cmd;
  logic        cmd_strobe;

  // Both write channels held; commit when response slot is free
  assign wr_go      = aw_held_reg && w_held_reg && !o_bvalid;
  assign cmd        = w_data_reg[2:0];
  assign cmd_strobe = wr_go && aw_addr_reg == ADDR_COMMAND && low_lane(w_strb_reg);
  assign wr_known   = aw_addr_reg == ADDR_CURSOR_SET_LOW || aw_addr_reg == ADDR_CURSOR_SET_HIGH
                   || aw_addr_reg == ADDR_PIXEL_DEPTH || aw_addr_reg == ADDR_PLL_DIVIDER
                   || aw_addr_reg == ADDR_PLL_MULT || aw_addr_reg == ADDR_COMMAND
                   || aw_addr_reg == ADDR_CONTROL;

  // Write address capture, either order with data
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end
    else if (i_awvalid && o_awready)
    begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= {i_awaddr[7:2], 2'b00};
    end
    else if (wr_go)
      aw_held_reg <= 1'b0;
  end

  // Write data capture
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end
    else if (i_wvalid && o_wready)
    begin
      w_held_reg <= 1'b1;
      w_data_reg <= i_wdata;
      w_strb_reg <= i_wstrb;
    end
    else if (wr_go)
      w_held_reg <= 1'b0;
  end

  // Ready only while the holding slot is empty
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
    end
    else
    begin
      o_awready <= !(aw_held_reg || (i_awvalid && o_awready)) || wr_go;
      o_wready  <= !(w_held_reg || (i_wvalid && o_wready)) || wr_go;
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // Staging registers; all but indirect_reg act only when a command moves them
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      set_low_reg  <= 8'h00;
      set_high_reg <= 7'h00;
      depth_reg    <= DEPTH_RESET;
      pll_div_reg  <= PLL_DIVIDER_RESET;
      pll_mult_reg <= PLL_MULT_RESET;
      indirect_reg <= 1'b1;
    end
    else if (wr_go && low_lane(w_strb_reg))
    begin
      case (aw_addr_reg)
        ADDR_CURSOR_SET_LOW:  set_low_reg  <= w_data_reg[7:0];
        ADDR_CURSOR_SET_HIGH: set_high_reg <= w_data_reg[6:0];
        ADDR_PIXEL_DEPTH:     depth_reg    <= w_data_reg[1:0];
        ADDR_PLL_DIVIDER:     pll_div_reg  <= w_data_reg[7:0];
        ADDR_PLL_MULT:        pll_mult_reg <= w_data_reg[7:0];
        ADDR_CONTROL:         indirect_reg <= w_data_reg[0];
        default:             indirect_reg <= indirect_reg;
      endcase
    end
  end

  // Cursor update; scroll and other commands fall to the hold branch
  always_comb
  begin
    cursor_next = cursor_reg;
    if (cmd_strobe)
    begin
      case (cmd)
        CMD_CURSOR_SET:   cursor_next = {set_high_reg, set_low_reg};
        CMD_MEMORY_READ,
        CMD_MEMORY_WRITE: cursor_next = indirect_reg ? cursor_reg + CURSOR_ONE : cursor_reg;
        default:          cursor_next = cursor_reg;
      endcase
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      cursor_reg <= 15'h0000;
    else
      cursor_reg <= cursor_next;
  end

  // Readback copy refreshed by the readback command
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      readback_reg <= 15'h0000;
    else if (cmd_strobe && cmd == CMD_CURSOR_READBACK)
      readback_reg <= cursor_reg;
  end

  // Memory strobes carry the pre-increment address
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_mem_addr       <= 15'h0000;
      o_mem_read       <= 1'b0;
      o_mem_write      <= 1'b0;
      o_direct_refused <= 1'b1;
    end
    else
    begin
      o_mem_addr       <= cursor_reg;
      o_mem_read       <= cmd_strobe && cmd == CMD_MEMORY_READ && indirect_reg;
      o_mem_write      <= cmd_strobe && cmd == CMD_MEMORY_WRITE && indirect_reg;
      o_direct_refused <= indirect_reg;
    end
  end

  // Applied settings, moved only by their commands
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_bits_per_pixel <= DEPTH_RESET;
      o_input_ratio    <= PLL_DIVIDER_RESET[3:0];
      o_output_ratio   <= PLL_DIVIDER_RESET[7:4];
      o_feedback_mult  <= PLL_MULT_RESET[3:0];
      o_pll_load       <= 1'b0;
    end
    else
    begin
      o_pll_load <= cmd_strobe && cmd == CMD_PLL_CONFIG;
      if (cmd_strobe && cmd == CMD_DEPTH_SELECT)
        o_bits_per_pixel <= depth_reg;
      if (cmd_strobe && cmd == CMD_PLL_CONFIG)
      begin
        o_output_ratio  <= pll_div_reg[7:4];
        // Reserved input codes clamp so the PLL never sees them
        o_input_ratio   <= (pll_div_reg[3:0] > INPUT_RATIO_MAX_CODE) ? INPUT_RATIO_MAX_CODE
                                                                     : pll_div_reg[3:0];
        o_feedback_mult <= pll_mult_reg[3:0];
      end
    end
  end

  // Read channel; write-only set registers read as zero
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= RESP_OKAY;
    end
    else if (o_rvalid)
    begin
      o_arready <= 1'b0;
      if (i_rready)
        o_rvalid <= 1'b0;
    end
    else if (i_arvalid && o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rresp   <= RESP_OKAY;
      case ({i_araddr[7:2], 2'b00})
        ADDR_CURSOR_SET_LOW, ADDR_CURSOR_SET_HIGH, ADDR_COMMAND: o_rdata <= 32'h0000_0000;
        ADDR_CURSOR_RB_LOW:   o_rdata <= {24'h000000, readback_reg[7:0]};
        ADDR_CURSOR_RB_HIGH:  o_rdata <= {25'h0000000, readback_reg[14:8]};
        ADDR_PIXEL_DEPTH:     o_rdata <= {30'h00000000, depth_reg};
        ADDR_PLL_DIVIDER:     o_rdata <= {24'h000000, pll_div_reg};
        ADDR_PLL_MULT:        o_rdata <= {24'h000000, pll_mult_reg};
        ADDR_PRODUCT_ID:      o_rdata <= {24'h000000, PRODUCT_CODE};
        ADDR_CONTROL:         o_rdata <= {17'h00000, cursor_reg};
        default:
        begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else
      o_arready <= 1'b1;
  end

  // Checks
  sequence mem_cmd_s;
    cmd_strobe && indirect_reg && (cmd == CMD_MEMORY_READ || cmd == CMD_MEMORY_WRITE);
  endsequence
  cursor_incr_a: assert property (@(posedge i_clock) disable iff (i_srst)
    mem_cmd_s |=> cursor_reg == $past(cursor_reg) + CURSOR_ONE)
    else $error("cursor did not advance after memory command");
  cursor_hold_a: assert property (@(posedge i_clock) disable iff (i_srst)
    !cmd_strobe |=> $stable(cursor_reg))
    else $error("cursor changed without command");
  cursor_set_a: assert property (@(posedge i_clock) disable iff (i_srst)
    cmd_strobe && cmd == CMD_CURSOR_SET |=> cursor_reg == {$past(set_high_reg), $past(set_low_reg)})
    else $error("cursor set mismatch");
  mem_addr_a: assert property (@(posedge i_clock) disable iff (i_srst)
    mem_cmd_s |=> (o_mem_read || o_mem_write) && o_mem_addr == $past(cursor_reg))
    else $error("memory strobe address wrong");
  direct_ref_a: assert property (@(posedge i_clock) disable iff (i_srst)
    !indirect_reg && cmd_strobe |=> !o_mem_read && !o_mem_write)
    else $error("memory strobe outside indirect mode");
  readback_a: assert property (@(posedge i_clock) disable iff (i_srst)
    cmd_strobe && cmd == CMD_CURSOR_READBACK |=> readback_reg == $past(cursor_reg))
    else $error("readback not captured");
  pll_load_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_pll_load |-> o_output_ratio == $past(pll_div_reg[7:4]) && o_feedback_mult == $past(pll_mult_reg[3:0]))
    else $error("pll settings not passed");
  input_ratio_a: assert property (@(posedge i_clock) disable iff (i_srst)
    o_input_ratio <= INPUT_RATIO_MAX_CODE)
    else $error("reserved input divider applied");
  depth_apply_a: assert property (@(posedge i_clock) disable iff (i_srst)
    cmd_strobe && cmd == CMD_DEPTH_SELECT |=> o_bits_per_pixel == $past(depth_reg))
    else $error("depth not applied");
  wrap_a: assert property (@(posedge i_clock) disable iff (i_srst)
    (mem_cmd_s and cursor_reg == 15'h7fff) |=> cursor_reg == 15'h0000)
    else $error("cursor did not wrap");

endmodule : cursor_depth_pll_config_regs
`default_nettype wire

//--- cursor_depth_pll_config_regs_test.sv
// Self-checking bench for the cursor, depth and PLL register bank
`default_nettype none
module cursor_depth_pll_config_regs_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cursor_regs_pkg::*;
  logic        clk, srst, awv, wv, bready, arv, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, mem_rd, mem_wr, pll_ld, refused;
  logic [1:0]  bresp, rresp, bpp;
  logic [14:0] mem_addr, last_addr;
  logic [3:0]  in_r, out_r, mult;
  logic [7:0]  strobes, loads;
  logic [7:0]  pd [2];
  logic [7:0]  pm [2];
  int          num_errors, check_count;

  cursor_depth_pll_config_regs uut (.i_clock(clk), .i_srst(srst), .i_awaddr(awaddr), .i_awvalid(awv),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wv), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_mem_addr(mem_addr), .o_mem_read(mem_rd), .o_mem_write(mem_wr), .o_bits_per_pixel(bpp),
    .o_input_ratio(in_r), .o_output_ratio(out_r), .o_feedback_mult(mult), .o_pll_load(pll_ld),
    .o_direct_refused(refused));

  mem_pll_model far (.i_clock(clk), .i_srst(srst), .i_mem_addr(mem_addr), .i_mem_read(mem_rd),
    .i_mem_write(mem_wr), .i_pll_load(pll_ld), .o_strobes(strobes), .o_last_addr(last_addr),
    .o_loads(loads));

  // Free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // A wait that runs out ends the run
  task automatic guard(input int n);
    if (n >= 100)
    begin
      num_errors++;
      $display("MISMATCH handshake expected answer seen none");
      test_done();
    end
  endtask

  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int   n;
    logic ad, wd;
    n = 0;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata  <= d;
    wstrb  <= 4'h1;
    awv    <= 1'b1;
    wv     <= 1'b1;
    while (!(ad && wd) && n < 100)
    begin
      @(posedge clk);
      n++;
      if (awv && awready)
      begin
        ad = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wready)
      begin
        wd = 1'b1;
        wv <= 1'b0;
      end
    end
    guard(n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (!bvalid && n < 100);
    guard(n);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arv    <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end while (!arready && n < 100);
    guard(n);
    arv <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (!rvalid && n < 100);
    guard(n);
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
  endtask

  // Command effects land a fixed few cycles after the response
  task automatic cmd(input logic [2:0] c);
    wr(ADDR_COMMAND, {29'h0, c}, RESP_OKAY);
    repeat (3) @(posedge clk);
  endtask

  initial
  begin
    srst = 1'b1;
    {awv, wv, arv} = 3'h0;
    {bready, rready} = 2'h3; // Responses always accepted at once
    {awaddr, araddr, wstrb} = 20'h0;
    wdata = 32'h0;
    pd = '{8'h7d, 8'hf1};
    pm = '{8'h0f, 8'h00};
    num_errors = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    // Values after reset
    chk("in_ratio", in_r, 32'h1);
    chk("out_ratio", out_r, 32'he);
    chk("mult", mult, 32'h9);
    chk("bpp", bpp, 32'h0);
    chk("cursor", mem_addr, 32'h0);
    chk("refused", refused, 32'h1);
    rd(ADDR_PLL_DIVIDER, 32'he1, RESP_OKAY);
    rd(ADDR_CURSOR_RB_LOW, 32'h0, RESP_OKAY);
    rd(ADDR_CURSOR_RB_HIGH, 32'h0, RESP_OKAY);
    rd(ADDR_PRODUCT_ID, {24'h0, PRODUCT_CODE_DEFAULT}, RESP_OKAY);
    rd(8'h50, 32'h0, RESP_SLVERR);
    wr(8'h50, 32'h1, RESP_SLVERR);
    // Top of range, so the increment must wrap; halves differ so a swap shows
    wr(ADDR_CURSOR_SET_HIGH, 32'h7f, RESP_OKAY);
    wr(ADDR_CURSOR_SET_LOW, 32'hff, RESP_OKAY);
    cmd(CMD_CURSOR_SET);
    chk("cursor", mem_addr, 32'h7fff);
    // Readback: low byte read first, then the high part
    cmd(CMD_CURSOR_READBACK);
    rd(ADDR_CURSOR_RB_LOW, 32'hff, RESP_OKAY);
    rd(ADDR_CURSOR_RB_HIGH, 32'h7f, RESP_OKAY);
    cmd(CMD_MEMORY_READ);
    chk("acc_addr", last_addr, 32'h7fff);
    chk("cursor", mem_addr, 32'h0);
    cmd(CMD_SCROLL);
    chk("cursor", mem_addr, 32'h0);
    cmd(CMD_MEMORY_WRITE);
    chk("acc_addr", last_addr, 32'h0);
    chk("cursor", mem_addr, 32'h1);
    chk("strobes", strobes, 32'h2);
    // Leaving indirect mode: memory commands have no effect
    wr(ADDR_CONTROL, 32'h0, RESP_OKAY);
    cmd(CMD_MEMORY_READ);
    chk("refused", refused, 32'h0);
    chk("strobes", strobes, 32'h2);
    chk("cursor", mem_addr, 32'h1);
    wr(ADDR_CONTROL, 32'h1, RESP_OKAY);
    cmd(CMD_CURSOR_READBACK);
    chk("refused", refused, 32'h1);
    // Every defined depth code; no text screen and no scroll setting live in this bench
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_PIXEL_DEPTH, i, RESP_OKAY);
      cmd(CMD_DEPTH_SELECT);
      chk("bpp", bpp, i);
      rd(ADDR_PIXEL_DEPTH, i, RESP_OKAY);
    end
    // Reserved input code clamps; settings keep both clocks in range at 100 MHz, no display running
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_PLL_DIVIDER, {24'h0, pd[i]}, RESP_OKAY);
      wr(ADDR_PLL_MULT, {24'h0, pm[i]}, RESP_OKAY);
      cmd(CMD_PLL_CONFIG);
      chk("in_ratio", in_r, (i == 0) ? 32'hc : 32'h1);
      chk("out_ratio", out_r, pd[i][7:4]);
      chk("mult", mult, pm[i][3:0]);
      chk("loads", loads, i + 1);
      rd(ADDR_PLL_DIVIDER, {24'h0, pd[i]}, RESP_OKAY);
    end
    test_done();
  end
endmodule // cursor_depth_pll_config_regs_test
`default_nettype wire

//--- cursor_regs_pkg.sv
// Package with register map, field layout and reset values of the cursor/depth/PLL bank
`default_nettype none
package cursor_regs_pkg;
  localparam logic [7:0]  OFS_CURSOR_SET_LOW    = 8'h1c;
  localparam logic [7:0]  OFS_CURSOR_SET_HIGH   = 8'h1d;
  localparam logic [7:0]  OFS_CURSOR_RB_LOW     = 8'h1e;
  localparam logic [7:0]  OFS_CURSOR_RB_HIGH    = 8'h1f;
  localparam logic [7:0]  OFS_PIXEL_DEPTH       = 8'h20;
  localparam logic [7:0]  OFS_PLL_DIVIDER       = 8'h31;
  localparam logic [7:0]  OFS_PRODUCT_ID        = 8'h21;
  localparam logic [7:0]  OFS_COMMAND           = 8'h22;
  localparam logic [7:0]  OFS_CONTROL           = 8'h23;
  localparam logic [7:0]  OFS_PLL_MULT          = 8'h32;
  // Offsets are word indices; used as byte addresses, four in a row would alias, so the byte address is four times the index
  localparam logic [7:0]  ADDR_CURSOR_SET_LOW   = {OFS_CURSOR_SET_LOW[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CURSOR_SET_HIGH  = {OFS_CURSOR_SET_HIGH[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CURSOR_RB_LOW    = {OFS_CURSOR_RB_LOW[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CURSOR_RB_HIGH   = {OFS_CURSOR_RB_HIGH[5:0], 2'b00};
  localparam logic [7:0]  ADDR_PIXEL_DEPTH      = {OFS_PIXEL_DEPTH[5:0], 2'b00};
  localparam logic [7:0]  ADDR_PLL_DIVIDER      = {OFS_PLL_DIVIDER[5:0], 2'b00};
  localparam logic [7:0]  ADDR_PRODUCT_ID       = {OFS_PRODUCT_ID[5:0], 2'b00};
  localparam logic [7:0]  ADDR_COMMAND          = {OFS_COMMAND[5:0], 2'b00};
  localparam logic [7:0]  ADDR_CONTROL          = {OFS_CONTROL[5:0], 2'b00};
  localparam logic [7:0]  ADDR_PLL_MULT         = {OFS_PLL_MULT[5:0], 2'b00};
  localparam logic [14:0] CURSOR_ONE            = 15'h0001;
  localparam logic [7:0]  PLL_DIVIDER_RESET     = 8'he1;
  localparam logic [7:0]  PLL_MULT_RESET        = 8'h09;
  localparam logic [1:0]  DEPTH_RESET           = 2'h0;
  localparam logic [3:0]  INPUT_RATIO_MAX_CODE  = 4'hc;
  localparam logic [7:0]  PRODUCT_CODE_DEFAULT  = 8'h5a; // Arbitrary value
  localparam logic [1:0]  RESP_OKAY             = 2'h0;
  localparam logic [1:0]  RESP_SLVERR           = 2'h2;
  // Command codes written to the command register
  localparam logic [2:0]  CMD_CURSOR_SET        = 3'h1;
  localparam logic [2:0]  CMD_CURSOR_READBACK   = 3'h2;
  localparam logic [2:0]  CMD_MEMORY_READ       = 3'h3;
  localparam logic [2:0]  CMD_MEMORY_WRITE      = 3'h4;
  localparam logic [2:0]  CMD_DEPTH_SELECT      = 3'h5;
  localparam logic [2:0]  CMD_PLL_CONFIG        = 3'h6;
  localparam logic [2:0]  CMD_SCROLL            = 3'h7;
endpackage : cursor_regs_pkg
`default_nettype wire

//--- mem_pll_model.sv
// Model of the display memory port and PLL that consume the bank's outputs
`default_nettype none
module mem_pll_model (
  input  wire logic        i_clock,     // System clock
  input  wire logic        i_srst,      // Sync reset, high
  input  wire logic [14:0] i_mem_addr,  // Cursor address
  input  wire logic        i_mem_read,  // Memory read strobe
  input  wire logic        i_mem_write, // Memory write strobe
  input  wire logic        i_pll_load,  // PLL load pulse
  output logic      [7:0]  o_strobes,   // Memory accesses seen
  output logic      [14:0] o_last_addr, // Address of last access
  output logic      [7:0]  o_loads      // PLL loads seen
);
  // Memory side records each access with the address it used
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
    begin
      o_strobes   <= 8'h00;
      o_last_addr <= 15'h0000;
    end
    else if (i_mem_read || i_mem_write)
    begin
      o_strobes   <= o_strobes + 8'h01;
      o_last_addr <= i_mem_addr;
    end
  end

  // PLL side counts parameter loads
  always_ff @(posedge i_clock)
  begin
    if (i_srst)
      o_loads <= 8'h00;
    else if (i_pll_load)
      o_loads <= o_loads + 8'h01;
  end
endmodule // mem_pll_model
`default_nettype wire
